// ==== logic/slmc_pkg.sv ====
// Summary of operation
// - halftone mask entries go row by row, left to right, top row first.
// - mask header horizontal and vertical sizes are sent equal, both eight.
// - gamma payload is a ten byte header, then the table entries.
// - gamma table identifier byte is zero, selecting black and white.
// - gamma table order byte is reserved and sent as zero.
// - bit padding type byte is reserved and sent as zero.
// - source size field holds 256 entries.
// - destination size field holds 256 entries.
// - scan length byte counts window identifier list bytes sent.
// - two-sided scan sends front and back window identifiers.
// - one-sided scan sends only the front window identifier.
package slmc_pkg;
  // ---------------------------------------------------------------
  // command and payload layout
  // ---------------------------------------------------------------
  localparam logic [7:0]  OP_SEND      = 8'h2a;
  localparam logic [7:0]  OP_SCAN      = 8'h1b;
  localparam logic [7:0]  DT_MASK      = 8'h02;
  localparam logic [7:0]  DT_GAMMA     = 8'h03;
  localparam logic [7:0]  HDR_LEN      = 8'h0a;
  localparam logic [7:0]  MASK_DIM     = 8'h08;
  localparam logic [7:0]  GAMMA_BW_ID  = 8'h00;
  localparam logic [15:0] TABLE_SIZE   = 16'h0100;
  localparam logic [7:0]  WIN_FRONT    = 8'h00;
  localparam logic [7:0]  WIN_BACK     = 8'h80;
  localparam logic [3:0]  SEND_CDB_LEN = 4'ha;
  localparam logic [3:0]  SCAN_CDB_LEN = 4'h6;
  localparam logic [6:0]  MASK_LEN     = 7'h40;
  localparam logic [10:0] MASK_TOTAL   = 11'h04a;
  localparam logic [10:0] GAMMA_TOTAL  = 11'h10a;
  localparam logic [10:0] LIST_SIMPLEX = 11'h001;
  localparam logic [10:0] LIST_DUPLEX  = 11'h002;
  localparam logic [7:0]  RSVD_ZERO    = 8'h00;

  // ---------------------------------------------------------------
  // byte positions within command blocks and payload headers
  // ---------------------------------------------------------------
  localparam logic [3:0]  POS_OPCODE   = 4'h0;
  localparam logic [3:0]  POS_TYPE     = 4'h2;
  localparam logic [3:0]  POS_SCAN_LEN = 4'h4;
  localparam logic [3:0]  POS_QUAL     = 4'h5;
  localparam logic [3:0]  POS_LEN_HI   = 4'h7;
  localparam logic [3:0]  POS_LEN_LO   = 4'h8;
  localparam logic [3:0]  POS_XSIZE_LO = 4'h5;
  localparam logic [3:0]  POS_YSIZE_LO = 4'h7;
  localparam logic [3:0]  POS_TBL_ID   = 4'h0;
  localparam logic [3:0]  POS_TBL_ORD  = 4'h2;
  localparam logic [3:0]  POS_PAD      = 4'h3;
  localparam logic [3:0]  POS_SRC_HI   = 4'h4;
  localparam logic [3:0]  POS_SRC_LO   = 4'h5;
  localparam logic [3:0]  POS_DST_HI   = 4'h6;
  localparam logic [3:0]  POS_DST_LO   = 4'h7;

  typedef enum logic [1:0] {SLMC_JOB_MASK, SLMC_JOB_GAMMA, SLMC_JOB_SCAN} slmc_job_t;
  typedef enum logic [1:0] {SLMC_IDLE, SLMC_CDB, SLMC_DATA, SLMC_WAIT} slmc_state_t;
endpackage

// ==== logic/slmc_byte_gen.sv ====
`timescale 1ns/1ps
// forms the byte at one stream position for each kind of transfer
module slmc_byte_gen (
  input  wire logic              [1:0]  job,        // slmc_pkg::slmc_job_t code
  input  wire logic              [10:0] pos,        // byte index within phase
  input  wire logic                     cdb_phase,  // high while sending command block
  input  wire logic              [2:0]  mask_id,    // halftone mask or gamma slot
  input  wire logic                     duplex,     // two-sided scan
  input  wire logic              [7:0]  mask_byte,  // threshold from mask store
  input  wire logic              [7:0]  gamma_byte, // entry from gamma store
  output logic                   [7:0]  dout        // byte to send
);
  logic [10:0] len;

  always_comb
  begin
    dout = slmc_pkg::RSVD_ZERO;
    unique case (job)
      slmc_pkg::SLMC_JOB_MASK:  len = slmc_pkg::MASK_TOTAL;
      slmc_pkg::SLMC_JOB_GAMMA: len = slmc_pkg::GAMMA_TOTAL;
      default:                  len = duplex ? slmc_pkg::LIST_DUPLEX : slmc_pkg::LIST_SIMPLEX;
    endcase
    if (cdb_phase)
    begin
      if (job == slmc_pkg::SLMC_JOB_SCAN)
      begin
        unique case (pos[3:0])
          slmc_pkg::POS_OPCODE:   dout = slmc_pkg::OP_SCAN;
          slmc_pkg::POS_SCAN_LEN: dout = len[7:0];
          default:                dout = slmc_pkg::RSVD_ZERO;
        endcase
      end
      else
      begin
        unique case (pos[3:0])
          slmc_pkg::POS_OPCODE: dout = slmc_pkg::OP_SEND;
          slmc_pkg::POS_TYPE:   dout = (job == slmc_pkg::SLMC_JOB_MASK) ? slmc_pkg::DT_MASK
                                                                       : slmc_pkg::DT_GAMMA;
          slmc_pkg::POS_QUAL:   dout = {5'h00, mask_id};
          slmc_pkg::POS_LEN_HI: dout = {5'h00, len[10:8]};
          slmc_pkg::POS_LEN_LO: dout = len[7:0];
          default:              dout = slmc_pkg::RSVD_ZERO;
        endcase
      end
    end
    else if (job == slmc_pkg::SLMC_JOB_SCAN)
      // front first, back only on a two-sided scan
      dout = (pos[0] && duplex) ? slmc_pkg::WIN_BACK : slmc_pkg::WIN_FRONT;
    else if (pos >= {3'h0, slmc_pkg::HDR_LEN})
      dout = (job == slmc_pkg::SLMC_JOB_MASK) ? mask_byte : gamma_byte;
    else if (job == slmc_pkg::SLMC_JOB_MASK)
    begin
      unique case (pos[3:0])
        slmc_pkg::POS_XSIZE_LO: dout = slmc_pkg::MASK_DIM;
        slmc_pkg::POS_YSIZE_LO: dout = slmc_pkg::MASK_DIM;
        default:                dout = slmc_pkg::RSVD_ZERO;
      endcase
    end
    else
    begin
      unique case (pos[3:0])
        slmc_pkg::POS_TBL_ID:  dout = slmc_pkg::GAMMA_BW_ID;
        slmc_pkg::POS_TBL_ORD: dout = slmc_pkg::RSVD_ZERO;
        slmc_pkg::POS_PAD:     dout = slmc_pkg::RSVD_ZERO;
        slmc_pkg::POS_SRC_HI:  dout = slmc_pkg::TABLE_SIZE[15:8];
        slmc_pkg::POS_SRC_LO:  dout = slmc_pkg::TABLE_SIZE[7:0];
        slmc_pkg::POS_DST_HI:  dout = slmc_pkg::TABLE_SIZE[15:8];
        slmc_pkg::POS_DST_LO:  dout = slmc_pkg::TABLE_SIZE[7:0];
        default:               dout = slmc_pkg::RSVD_ZERO;
      endcase
    end
  end
endmodule

// ==== logic/slmc_host.sv ====
`timescale 1ns/1ps
module slmc_host (
  input  wire logic        core_clk,     // 40 MHz clock
  input  wire logic        rst_b,        // async reset, active low
  // user side
  input  wire logic        wr_en,        // table write strobe
  input  wire logic        wr_sel,       // 0 mask store, 1 gamma store
  input  wire logic [7:0]  wr_addr,      // entry index, row major for mask
  input  wire logic [7:0]  wr_data,      // entry value
  input  wire logic        start,        // start one transfer, pulse
  input  wire logic [1:0]  job,          // 0 mask, 1 gamma, 2 scan
  input  wire logic [2:0]  slot_id,      // mask or gamma slot identifier
  input  wire logic        duplex,       // two-sided scan list
  output logic             busy,         // transfer in progress
  output logic             done,         // transfer finished, pulse
  output logic             rejected,     // device reported check condition
  // device side byte stream
  output logic             cmd_valid,    // byte on cmd_data is command block
  output logic             dat_valid,    // byte on cmd_data is data out
  output logic      [7:0]  cmd_data,     // outgoing byte
  input  wire logic        dev_ready,    // device takes the byte this cycle
  input  wire logic        stat_valid,   // status byte from device
  input  wire logic        stat_check    // status is check condition
);
  // ---------------------------------------------------------------
  // reset release and state
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  typedef struct packed {
    slmc_pkg::slmc_state_t st;
    logic [1:0]            job;
    logic [2:0]            slot;
    logic                  duplex;
    logic [10:0]           pos;
    logic [10:0]           len;
    logic                  busy;
    logic                  done;
    logic                  rejected;
    logic                  cmd_valid;
    logic                  dat_valid;
    logic [7:0]            data;
  } slmc_regs_t;

  slmc_regs_t r_q;
  slmc_regs_t r_d;

  // payload stores; mask row major so index equals stream order
  logic [7:0]  mask_mem  [0:63];
  logic [7:0]  gamma_mem [0:255];
  logic [7:0]  byte_out;
  logic [10:0] nxt_pos;
  logic        nxt_cdb;
  logic [10:0] ent;
  logic        idle;
  logic        start_ok;
  logic [1:0]  sel_job;
  logic [2:0]  sel_slot;
  logic        sel_duplex;
  logic [10:0] cdb_len;
  logic [10:0] dat_len;

  // ---------------------------------------------------------------
  // table stores
  // ---------------------------------------------------------------
  // no reset on the stores: the user loads them before the first send
  always_ff @(posedge core_clk)
  begin
    if (wr_en && !wr_sel)
      mask_mem[wr_addr[5:0]] <= wr_data;
    if (wr_en && wr_sel)
      gamma_mem[wr_addr] <= wr_data;
  end

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  // while idle the byte former looks at the user inputs, so the opcode is
  // ready in the very cycle that start is taken
  always_comb
  begin
    idle       = (r_q.st == slmc_pkg::SLMC_IDLE);
    start_ok   = idle && start && (job != 2'h3);
    sel_job    = idle ? job : r_q.job;
    sel_slot   = idle ? slot_id : r_q.slot;
    sel_duplex = idle ? duplex : r_q.duplex;
    if (job == slmc_pkg::SLMC_JOB_SCAN)
      cdb_len = {7'h00, slmc_pkg::SCAN_CDB_LEN};
    else
      cdb_len = {7'h00, slmc_pkg::SEND_CDB_LEN};
    unique case (r_q.job)
      slmc_pkg::SLMC_JOB_MASK:  dat_len = slmc_pkg::MASK_TOTAL;
      slmc_pkg::SLMC_JOB_GAMMA: dat_len = slmc_pkg::GAMMA_TOTAL;
      default:                  dat_len = r_q.duplex ? slmc_pkg::LIST_DUPLEX
                                                     : slmc_pkg::LIST_SIMPLEX;
    endcase
  end

  // ---------------------------------------------------------------
  // next byte selection
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_cdb = 1'b0;
    nxt_pos = r_q.pos + 11'h001;
    unique case (r_q.st)
      slmc_pkg::SLMC_IDLE:
      begin
        nxt_cdb = 1'b1;
        nxt_pos = 11'h000;
      end
      slmc_pkg::SLMC_CDB:
        nxt_cdb = (r_q.pos + 11'h001) < r_q.len ? 1'b1 : 1'b0;
      slmc_pkg::SLMC_DATA, slmc_pkg::SLMC_WAIT:
        nxt_cdb = 1'b0;
    endcase
    // the data phase restarts the count, so header offsets start at zero
    if (r_q.st == slmc_pkg::SLMC_CDB && !nxt_cdb)
      nxt_pos = 11'h000;
    ent = nxt_pos - {3'h0, slmc_pkg::HDR_LEN};
  end

  slmc_byte_gen u_gen (
    .job        (sel_job),
    .pos        (nxt_pos),
    .cdb_phase  (nxt_cdb),
    .mask_id    (sel_slot),
    .duplex     (sel_duplex),
    .mask_byte  (mask_mem[ent[5:0]]),
    .gamma_byte (gamma_mem[ent[7:0]]),
    .dout       (byte_out)
  );

  // ---------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    r_d      = r_q;
    r_d.done = 1'b0;
    unique case (r_q.st)
      slmc_pkg::SLMC_IDLE:
        if (start_ok)
        begin
          r_d.st        = slmc_pkg::SLMC_CDB;
          r_d.job       = job;
          r_d.slot      = slot_id;
          r_d.duplex    = duplex;
          r_d.pos       = 11'h000;
          r_d.len       = cdb_len;
          r_d.busy      = 1'b1;
          r_d.rejected  = 1'b0;
          r_d.cmd_valid = 1'b1;
          r_d.data      = byte_out;
        end
      slmc_pkg::SLMC_CDB, slmc_pkg::SLMC_DATA:
        if (dev_ready)
        begin
          r_d.pos  = nxt_pos;
          r_d.data = byte_out;
          if (r_q.st == slmc_pkg::SLMC_DATA && nxt_pos >= r_q.len)
          begin
            r_d.st        = slmc_pkg::SLMC_WAIT;
            r_d.dat_valid = 1'b0;
          end
          else if (r_q.st == slmc_pkg::SLMC_CDB && !nxt_cdb)
          begin
            r_d.st        = slmc_pkg::SLMC_DATA;
            r_d.cmd_valid = 1'b0;
            r_d.dat_valid = 1'b1;
            r_d.len       = dat_len;
          end
        end
      slmc_pkg::SLMC_WAIT:
        if (stat_valid)
        begin
          r_d.st       = slmc_pkg::SLMC_IDLE;
          r_d.busy     = 1'b0;
          r_d.done     = 1'b1;
          r_d.rejected = stat_check;
        end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      r_q <= '{st: slmc_pkg::SLMC_IDLE, default: '0};
    else
      r_q <= r_d;
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign busy      = r_q.busy;
  assign done      = r_q.done;
  assign rejected  = r_q.rejected;
  assign cmd_valid = r_q.cmd_valid;
  assign dat_valid = r_q.dat_valid;
  assign cmd_data  = r_q.data;
endmodule

// ==== verif/slmc_host_assertions.sv ====
`timescale 1ns/1ps
module slmc_host_chk (
  input wire logic       core_clk,   // clock
  input wire logic       rst_b,      // reset, active low
  input wire logic       start,      // start pulse
  input wire logic [1:0] job,        // transfer kind
  input wire logic       busy,       // in progress
  input wire logic       done,       // finished pulse
  input wire logic       rejected,   // check condition seen
  input wire logic       cmd_valid,  // command byte
  input wire logic       dat_valid,  // data byte
  input wire logic [7:0] cmd_data,   // outgoing byte
  input wire logic       dev_ready,  // byte taken
  input wire logic       stat_valid, // status present
  input wire logic       stat_check  // check condition
);
  // ---------------------------
  // stream properties
  // ---------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_start_opcode: assert property (start && !busy && !done && job != 2'h3
    |=> busy && cmd_valid && cmd_data == ((job == 2'h2) ? 8'h1b : 8'h2a))
    else $error("opcode not offered after start");
  chk_cmd_hold: assert property (cmd_valid && !dev_ready |=> cmd_valid && $stable(cmd_data))
    else $error("command byte dropped while stalled");
  chk_dat_hold: assert property (dat_valid && !dev_ready |=> dat_valid && $stable(cmd_data))
    else $error("data byte dropped while stalled");
  chk_phase_excl: assert property (!(cmd_valid && dat_valid))
    else $error("command and data offered together");
  chk_first_data: assert property ($rose(dat_valid) |-> cmd_data == 8'h00)
    else $error("first data byte not zero");
  chk_done_stat: assert property (busy && !cmd_valid && !dat_valid && stat_valid |=> done)
    else $error("status not completed");
  chk_done_idle: assert property (done |-> !busy && !cmd_valid && !dat_valid)
    else $error("still active at done");
  chk_reject_lvl: assert property (done |-> rejected == $past(stat_check))
    else $error("rejected does not follow status");
  chk_valid_busy: assert property (cmd_valid || dat_valid |-> busy)
    else $error("byte offered while idle");
endmodule
bind slmc_host slmc_host_chk u_chk (.core_clk, .rst_b, .start, .job, .busy, .done, .rejected,
  .cmd_valid, .dat_valid, .cmd_data, .dev_ready, .stat_valid, .stat_check);

// ==== verif/slmc_dev_model.sv ====
`timescale 1ns/1ps
module slmc_dev_model (
  input  wire logic       core_clk,   // clock
  input  wire logic       cmd_valid,  // command byte offered
  input  wire logic       dat_valid,  // data byte offered
  input  wire logic [7:0] cmd_data,   // offered byte
  input  wire logic       slow,       // stall every other cycle
  input  wire logic       fail,       // answer check condition
  output logic            dev_ready,  // byte taken this edge
  output logic            stat_valid, // status byte
  output logic            stat_check  // check condition
);
  logic [7:0]  rx [$];
  logic [15:0] want = 16'h0000;
  logic        tog  = 1'b0;
  int          ndat = 0;
  initial stat_valid = 1'b0;
  initial stat_check = 1'b0;
  assign dev_ready = ~slow | tog;
  always @(posedge core_clk)
  begin
    tog <= ~tog;
    stat_valid <= 1'b0;
    stat_check <= 1'b0;
    if (cmd_valid && dev_ready)
    begin
      ndat <= 0;
      if (rx.size() == 4 && rx[0] == 8'h1b) want <= {8'h00, cmd_data};
      if (rx.size() == 8) want <= {rx[7], cmd_data};
      if (rx.size() == 5 && rx[0] == 8'h1b && want == 16'h0000) stat_valid <= 1'b1;
      rx.push_back(cmd_data);
    end
    if (dat_valid && dev_ready)
    begin
      ndat <= ndat + 1;
      if (ndat + 1 == int'(want)) stat_valid <= 1'b1;
      if (ndat + 1 == int'(want)) stat_check <= fail;
      rx.push_back(cmd_data);
    end
  end
endmodule

// ==== verif/scan_lut_mask_command_parser_test.sv ====
`timescale 1ns/1ps
module scan_lut_mask_command_parser_test;
  logic       core_clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, wr_sel = 1'b0, start = 1'b0;
  logic       duplex = 1'b0, slow = 1'b0, fail = 1'b0;
  logic [7:0] wr_addr = 8'h00, wr_data = 8'h00, cmd_data;
  logic [1:0] job = 2'h0;
  logic [2:0] slot_id = 3'h0;
  logic       busy, done, rejected, cmd_valid, dat_valid, dev_ready, stat_valid, stat_check;
  logic [7:0] ex [$];
  int         error_cnt = 0, n_checks = 0;
  initial forever #12.5 core_clk = ~core_clk;
  slmc_host dut (.core_clk, .rst_b, .wr_en, .wr_sel, .wr_addr, .wr_data, .start, .job,
    .slot_id, .duplex, .busy, .done, .rejected, .cmd_valid, .dat_valid, .cmd_data,
    .dev_ready, .stat_valid, .stat_check);
  slmc_dev_model m (.core_clk, .cmd_valid, .dat_valid, .cmd_data, .slow, .fail,
    .dev_ready, .stat_valid, .stat_check);
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {wr_en, wr_sel, wr_addr, wr_data} = {1'b1, s, a, d};
    @(negedge core_clk);
    wr_en = 1'b0;
  endtask
  // ---------------------------
  // one transfer, stream compared
  // ---------------------------
  task automatic xfer(input logic [1:0] j);
    int n;
    m.rx.delete();
    @(negedge core_clk);
    {job, start} = {j, 1'b1};
    @(negedge core_clk);
    start = 1'b0;
    for (n = 0; n < 2000 && done !== 1'b1; n++) @(negedge core_clk);
    chk(done === 1'b1, "no done");
    chk(m.rx.size() == ex.size(), "stream length");
    foreach (ex[i]) chk(m.rx[i] === ex[i], "stream byte");
  endtask
  task automatic t_mask;
    for (int i = 0; i < 64; i++) wr(1'b0, 8'(63 - i), 8'hc3 ^ 8'(63 - i));
    {slot_id, slow} = {3'h5, 1'b1};
    ex = {8'h2a, 8'h00, 8'h02, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h4a, 8'h00,
          8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h00};
    for (int i = 0; i < 64; i++) ex.push_back(8'hc3 ^ 8'(i));
    xfer(2'h0);
    $display("mask test done");
  endtask
  task automatic t_gamma;
    for (int i = 0; i < 256; i++) wr(1'b1, 8'(i), 8'h5a ^ 8'(i));
    {slot_id, slow} = {3'h7, 1'b0};
    ex = {8'h2a, 8'h00, 8'h03, 8'h00, 8'h00, 8'h07, 8'h00, 8'h01, 8'h0a, 8'h00,
          8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 256; i++) ex.push_back(8'h5a ^ 8'(i));
    xfer(2'h1);
    $display("gamma test done");
  endtask
  task automatic t_scan(input logic d);
    {duplex, slow} = {d, d};
    ex = {8'h1b, 8'h00, 8'h00, 8'h00, 8'h01 + 8'(d), 8'h00, 8'h00};
    if (d) ex.push_back(8'h80);
    xfer(2'h2);
    chk(rejected === 1'b0, "scan rejected");
    $display("scan test done");
  endtask
  task automatic t_reject;
    fail = 1'b1;
    xfer(2'h2);
    chk(rejected === 1'b1, "check condition lost");
    fail = 1'b0;
    xfer(2'h2);
    chk(rejected === 1'b0, "rejected not cleared");
    $display("reject test done");
  endtask
  task automatic t_ignore;
    @(negedge core_clk);
    {job, start} = {2'h3, 1'b1};
    @(negedge core_clk);
    start = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(busy === 1'b0 && cmd_valid === 1'b0, "unknown job started");
    $display("ignore test done");
  endtask
  initial
  begin
    repeat (16) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    t_mask();
    t_gamma();
    t_scan(1'b0);
    t_scan(1'b1);
    t_reject();
    t_ignore();
    conclude();
  end
  // tests need about 1200 cycles; allow over sixteen times that
  initial
  begin
    #500000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
